// File: cdm_consts.svh
// register indices, field positions and reset values of the carrier data mixer
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH

`define CDM_ADDR_W 14
`define CDM_IDX_W 12
`define CDM_IDX_CON0 12'h0F4C
`define CDM_IDX_CON1 12'h0F4D
`define CDM_IDX_SRC 12'h0F4E
`define CDM_IDX_CARRIER_LOW 12'h0F4F
`define CDM_IDX_CARRIER_HIGH 12'h0F50
`define CDM_IDX_PWR 12'h0F51

`define CDM_CON0_EN_BIT 7
`define CDM_CON0_OUT_BIT 5
`define CDM_CON0_OUTPUT_INVERT_BIT 4
`define CDM_CON0_SWBIT_BIT 0
`define CDM_CON1_CHINV_BIT 5
`define CDM_CON1_CARRIER_HIGH_SYNC_ENABLE_BIT 4
`define CDM_CON1_CLINV_BIT 1
`define CDM_CON1_CARRIER_LOW_SYNC_ENABLE_BIT 0
`define CDM_PWR_DIS_BIT 0

`define CDM_SRC_W 5
`define CDM_CAR_W 4
`define CDM_SRC_N 24
`define CDM_CAR_N 16

`define CDM_RST_FLAG 1'b0
`define CDM_RST_SRC 5'h00
`define CDM_RST_CAR 4'h0
`define CDM_RST_WORD 32'h0000_0000

`endif

// File: cdm_pkg.sv
// types shared by the carrier data mixer files
package cdm_pkg;

  typedef enum logic {
    CDM_BUS_IDLE,
    CDM_BUS_ACK
  } cdm_bus_t;

  typedef struct packed {
    logic en;
    logic output_invert;
    logic sw_bit;
    logic ch_inv;
    logic ch_sync;
    logic cl_inv;
    logic cl_sync;
    logic [4:0] src_sel;
    logic [3:0] carrier_high_select;
    logic [3:0] carrier_low_select;
    logic pwr_dis;
    logic use_high;
    cdm_bus_t bus;
    logic [31:0] rdata;
  } cdm_state_t;

endpackage

// File: cdm_src_mux.sv
// source selector: one entry per code, unknown codes give low
`timescale 1ns/1ns
module cdm_src_mux #(
  parameter int N = 16,
  parameter int SEL_W = 4
) (
  input wire logic [N-1:0] src_i,
  input wire logic [SEL_W-1:0] sel_i,
  output logic src_o
);

  logic [N-1:0] hit;

  // and-or tree keeps the path free of clocked elements
  for (genvar g = 0; g < N; g++) begin : g_entry
    assign hit[g] = src_i[g] & (sel_i == SEL_W'(g));
  end

  assign src_o = |hit;

endmodule // cdm_src_mux

// File: cdm_mixer.sv
// carrier data mixer with avalon-mm register slave
`timescale 1ns/1ns
`include "cdm_consts.svh"

module cdm_mixer
  import cdm_pkg::*;
#(
  parameter int ADDR_W = `CDM_ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic modulator_pin_route_i,
  input wire logic carrier_high_pin_route_i,
  input wire logic carrier_low_pin_route_i,
  input wire logic internal_fast_oscillator_i,
  input wire logic reference_clock_output_i,
  input wire logic [1:0] capture_compare_unit_output_i,
  input wire logic [1:0] pulse_width_unit_output_i,
  input wire logic [1:0] comparator_output_i,
  input wire logic [1:0] serial_unit_data_i,
  input wire logic [1:0] serial_unit_transmit_i,
  input wire logic [1:0] sync_serial_data_out_i,
  input wire logic [7:0] logic_cell_output_i,
  output logic modulated_output_pin_o
);

  cdm_state_t st_reg;
  cdm_state_t st_next;

  logic [`CDM_SRC_N-1:0] mod_vec;
  logic [`CDM_CAR_N-1:0] carrier_high_vec;
  logic [`CDM_CAR_N-1:0] carrier_low_vec;
  logic modulator_signal;
  logic carrier_high_raw;
  logic carrier_low_raw;
  logic carrier_high;
  logic carrier_low;
  logic use_high;
  logic mixed;
  logic req;
  logic [`CDM_IDX_W-1:0] idx;
  logic addr_aligned;
  logic wr_take;
  logic [7:0] wbyte;

  // modulator source table, gaps tied low
  assign mod_vec = {
    logic_cell_output_i,
    2'b00,
    serial_unit_transmit_i[1],
    serial_unit_data_i[1],
    sync_serial_data_out_i[1],
    sync_serial_data_out_i[0],
    serial_unit_transmit_i[0],
    serial_unit_data_i[0],
    comparator_output_i,
    pulse_width_unit_output_i,
    capture_compare_unit_output_i,
    st_reg.sw_bit,
    modulator_pin_route_i
  };

  // the system clock is offered as a carrier, so clk_i feeds the data path here
  assign carrier_high_vec = {
    logic_cell_output_i,
    pulse_width_unit_output_i,
    capture_compare_unit_output_i,
    reference_clock_output_i,
    internal_fast_oscillator_i,
    clk_i,
    carrier_high_pin_route_i
  };

  assign carrier_low_vec = {
    logic_cell_output_i,
    pulse_width_unit_output_i,
    capture_compare_unit_output_i,
    reference_clock_output_i,
    internal_fast_oscillator_i,
    clk_i,
    carrier_low_pin_route_i
  };

  cdm_src_mux #(
    .N(`CDM_SRC_N),
    .SEL_W(`CDM_SRC_W)
  ) u_mod_mux (
    .src_i(mod_vec),
    .sel_i(st_reg.src_sel),
    .src_o(modulator_signal)
  );

  cdm_src_mux #(
    .N(`CDM_CAR_N),
    .SEL_W(`CDM_CAR_W)
  ) u_carrier_high_mux (
    .src_i(carrier_high_vec),
    .sel_i(st_reg.carrier_high_select),
    .src_o(carrier_high_raw)
  );

  cdm_src_mux #(
    .N(`CDM_CAR_N),
    .SEL_W(`CDM_CAR_W)
  ) u_carrier_low_mux (
    .src_i(carrier_low_vec),
    .sel_i(st_reg.carrier_low_select),
    .src_o(carrier_low_raw)
  );

  assign carrier_high = carrier_high_raw ^ st_reg.ch_inv;
  assign carrier_low = carrier_low_raw ^ st_reg.cl_inv;

  // without sync the switch follows the modulator at once; with sync the
  // registered choice holds the old carrier until its pulse has ended
  always_comb begin
    if (modulator_signal && !st_reg.cl_sync) begin
      use_high = 1'b1;
    end else if (!modulator_signal && !st_reg.ch_sync) begin
      use_high = 1'b0;
    end else begin
      use_high = st_reg.use_high;
    end
  end

  // no flop in this path: carriers above clk_i rate still pass, and only the clk_i carrier and a
  // changeover with its sync bit set depend on clk_i running here, so sleep stops nothing else
  always_comb begin
    if (use_high) begin
      mixed = modulator_signal & carrier_high;
    end else begin
      mixed = ~modulator_signal & carrier_low;
    end
  end

  // the pin is deliberately not registered, unlike every other output
  assign modulated_output_pin_o = st_reg.en & (mixed ^ st_reg.output_invert);

  assign req = avs_read_i | avs_write_i;
  assign idx = avs_address_i[ADDR_W-1:2];
  assign addr_aligned = (avs_address_i[1:0] == 2'b00);
  assign wr_take = avs_write_i && (st_reg.bus == CDM_BUS_ACK) && avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  always_comb begin
    st_next = st_reg;

    // bus handshake: one wait cycle, then one cycle with waitrequest low
    case (st_reg.bus)
      CDM_BUS_IDLE: begin
        if (req) begin
          st_next.bus = CDM_BUS_ACK;
        end
      end
      CDM_BUS_ACK: begin
        st_next.bus = CDM_BUS_IDLE;
      end
      default: begin
        st_next.bus = CDM_BUS_IDLE;
      end
    endcase

    // read data prepared during the wait cycle and shown at the answer
    st_next.rdata = `CDM_RST_WORD;
    if (avs_read_i && st_reg.bus == CDM_BUS_IDLE && addr_aligned) begin
      case (idx)
        `CDM_IDX_CON0: begin
          st_next.rdata[`CDM_CON0_EN_BIT] = st_reg.en;
          st_next.rdata[`CDM_CON0_OUT_BIT] = modulated_output_pin_o;
          st_next.rdata[`CDM_CON0_OUTPUT_INVERT_BIT] = st_reg.output_invert;
          st_next.rdata[`CDM_CON0_SWBIT_BIT] = st_reg.sw_bit;
        end
        `CDM_IDX_CON1: begin
          st_next.rdata[`CDM_CON1_CHINV_BIT] = st_reg.ch_inv;
          st_next.rdata[`CDM_CON1_CARRIER_HIGH_SYNC_ENABLE_BIT] = st_reg.ch_sync;
          st_next.rdata[`CDM_CON1_CLINV_BIT] = st_reg.cl_inv;
          st_next.rdata[`CDM_CON1_CARRIER_LOW_SYNC_ENABLE_BIT] = st_reg.cl_sync;
        end
        `CDM_IDX_SRC: begin
          st_next.rdata[`CDM_SRC_W-1:0] = st_reg.src_sel;
        end
        `CDM_IDX_CARRIER_LOW: begin
          st_next.rdata[`CDM_CAR_W-1:0] = st_reg.carrier_low_select;
        end
        `CDM_IDX_CARRIER_HIGH: begin
          st_next.rdata[`CDM_CAR_W-1:0] = st_reg.carrier_high_select;
        end
        `CDM_IDX_PWR: begin
          st_next.rdata[`CDM_PWR_DIS_BIT] = st_reg.pwr_dis;
        end
        default: begin
          st_next.rdata = `CDM_RST_WORD;
        end
      endcase
    end

    // writes land at the edge where waitrequest is seen low
    if (wr_take && addr_aligned) begin
      case (idx)
        `CDM_IDX_CON0: begin
          st_next.en = wbyte[`CDM_CON0_EN_BIT];
          st_next.output_invert = wbyte[`CDM_CON0_OUTPUT_INVERT_BIT];
          st_next.sw_bit = wbyte[`CDM_CON0_SWBIT_BIT];
        end
        `CDM_IDX_CON1: begin
          st_next.ch_inv = wbyte[`CDM_CON1_CHINV_BIT];
          st_next.ch_sync = wbyte[`CDM_CON1_CARRIER_HIGH_SYNC_ENABLE_BIT];
          st_next.cl_inv = wbyte[`CDM_CON1_CLINV_BIT];
          st_next.cl_sync = wbyte[`CDM_CON1_CARRIER_LOW_SYNC_ENABLE_BIT];
        end
        `CDM_IDX_SRC: begin
          st_next.src_sel = wbyte[`CDM_SRC_W-1:0];
        end
        `CDM_IDX_CARRIER_LOW: begin
          st_next.carrier_low_select = wbyte[`CDM_CAR_W-1:0];
        end
        `CDM_IDX_CARRIER_HIGH: begin
          st_next.carrier_high_select = wbyte[`CDM_CAR_W-1:0];
        end
        `CDM_IDX_PWR: begin
          st_next.pwr_dis = wbyte[`CDM_PWR_DIS_BIT];
        end
        default: begin
          st_next.pwr_dis = st_reg.pwr_dis;
        end
      endcase
    end

    // carrier changeover: with its sync bit set, the leaving carrier must be seen low on clk_i;
    // a carrier much faster than clk_i may be sampled high repeatedly
    if (!st_reg.en) begin
      st_next.use_high = modulator_signal;
    end else if (modulator_signal != st_reg.use_high) begin
      if (modulator_signal) begin
        if (!st_reg.cl_sync || !carrier_low) begin
          st_next.use_high = 1'b1;
        end
      end else begin
        if (!st_reg.ch_sync || !carrier_high) begin
          st_next.use_high = 1'b0;
        end
      end
    end

    // power disable holds every control at its default until cleared
    if (st_reg.pwr_dis) begin
      st_next.en = `CDM_RST_FLAG;
      st_next.output_invert = `CDM_RST_FLAG;
      st_next.sw_bit = `CDM_RST_FLAG;
      st_next.ch_inv = `CDM_RST_FLAG;
      st_next.ch_sync = `CDM_RST_FLAG;
      st_next.cl_inv = `CDM_RST_FLAG;
      st_next.cl_sync = `CDM_RST_FLAG;
      st_next.src_sel = `CDM_RST_SRC;
      st_next.carrier_high_select = `CDM_RST_CAR;
      st_next.carrier_low_select = `CDM_RST_CAR;
      st_next.use_high = `CDM_RST_FLAG;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg.en <= `CDM_RST_FLAG;
      st_reg.output_invert <= `CDM_RST_FLAG;
      st_reg.sw_bit <= `CDM_RST_FLAG;
      st_reg.ch_inv <= `CDM_RST_FLAG;
      st_reg.ch_sync <= `CDM_RST_FLAG;
      st_reg.cl_inv <= `CDM_RST_FLAG;
      st_reg.cl_sync <= `CDM_RST_FLAG;
      st_reg.src_sel <= `CDM_RST_SRC;
      st_reg.carrier_high_select <= `CDM_RST_CAR;
      st_reg.carrier_low_select <= `CDM_RST_CAR;
      st_reg.pwr_dis <= `CDM_RST_FLAG;
      st_reg.use_high <= `CDM_RST_FLAG;
      st_reg.bus <= CDM_BUS_IDLE;
      st_reg.rdata <= `CDM_RST_WORD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_o = st_reg.rdata;
  assign avs_waitrequest_o = (st_reg.bus != CDM_BUS_ACK);

endmodule // cdm_mixer

// File: cdm_mixer_asserts.sv
// checker for the bus handshake and the output pin of the carrier data mixer
`timescale 1ns/1ns
module cdm_mixer_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [13:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic modulated_output_pin_o
);
  logic req, hit, en_reg, en_next;
  // shadow of the enable bit; power disable is not followed, which only weakens a_off
  assign req = avs_read_i || avs_write_i;
  assign hit = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign en_next = (hit && avs_address_i == 14'h3d30) ? avs_writedata_i[7] : en_reg;
  always_ff @(posedge clk_i)
    en_reg <= rst_n_i ? en_next : 1'b0;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_take;
    req && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_idle;
    !req |=> avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_rd_zero;
    avs_waitrequest_o |-> avs_readdata_o == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer");
  property p_rd_hi;
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_rst;
    $rose(rst_n_i) |-> avs_waitrequest_o && !modulated_output_pin_o && avs_readdata_o == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_off;
    !en_reg |-> !modulated_output_pin_o;
  endproperty
  a_off: assert property (p_off) else $error("pin high while disabled");
  property p_stat;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 14'h3d30
      |-> avs_readdata_o[5] == $past(modulated_output_pin_o);
  endproperty
  a_stat: assert property (p_stat) else $error("status bit differs from pin");
endmodule // cdm_mixer_asserts

bind cdm_mixer cdm_mixer_asserts chk (.*);

// File: cdm_sources.sv
// stand-in for the peripherals, oscillators and pins feeding the mixer
`timescale 1ns/1ns
module cdm_sources (
  input wire logic [24:0] pat_i,
  output logic mpin_o,
  output logic hpin_o,
  output logic lpin_o,
  output logic hfo_o,
  output logic rco_o,
  output logic [1:0] ccp_o,
  output logic [1:0] pwm_o,
  output logic [1:0] cmp_o,
  output logic [1:0] sud_o,
  output logic [1:0] sut_o,
  output logic [1:0] ssd_o,
  output logic [7:0] lc_o
);
  // plain levels: on-chip sources always drive, so no released value exists
  assign {lc_o, ssd_o, sut_o, sud_o, cmp_o, pwm_o, ccp_o} = pat_i[24:5];
  assign {rco_o, hfo_o, lpin_o, hpin_o, mpin_o} = pat_i[4:0];
endmodule // cdm_sources

// File: cdm_mixer_test.sv
// self-checking bench for the carrier data mixer
`timescale 1ns/1ns
module cdm_mixer_test;
  logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [13:0] avs_address_i = '0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic avs_waitrequest_o, modulated_output_pin_o, mpin_o, hpin_o, lpin_o, hfo_o, rco_o;
  logic [1:0] ccp_o, pwm_o, cmp_o, sud_o, sut_o, ssd_o;
  logic [7:0] lc_o;
  logic [24:0] pat = '0;
  logic en = 1'b0, output_invert = 1'b0, sw = 1'b0, hi = 1'b0, li = 1'b0, hs = 1'b0, ls = 1'b0;
  logic [4:0] s = '0;
  logic [3:0] h = '0, l = '0;
  logic [31:0] expq[$];
  int num_errors = 0, tests_run = 0;
  always #20 clk_i = ~clk_i;
  cdm_sources src (.pat_i(pat), .*);
  cdm_mixer uut (.*, .modulator_pin_route_i(mpin_o), .carrier_high_pin_route_i(hpin_o),
    .carrier_low_pin_route_i(lpin_o), .internal_fast_oscillator_i(hfo_o),
    .reference_clock_output_i(rco_o), .capture_compare_unit_output_i(ccp_o),
    .pulse_width_unit_output_i(pwm_o), .comparator_output_i(cmp_o), .serial_unit_data_i(sud_o),
    .serial_unit_transmit_i(sut_o), .sync_serial_data_out_i(ssd_o), .logic_cell_output_i(lc_o));
  function automatic logic model();
    logic [31:0] mv;
    logic [15:0] hv, lv;
    // codes 0 and 1 are the pin and the software bit; the table starts there
    mv = {8'h0, pat[24:17], 2'b0, pat[14], pat[12], pat[16:15], pat[13], pat[11], pat[10:5],
      sw, pat[0]};
    hv = {pat[24:17], pat[8:3], clk_i, pat[1]};
    lv = {pat[24:17], pat[8:3], clk_i, pat[2]};
    return en & ((mv[s] ? hv[h] ^ hi : lv[l] ^ li) ^ output_invert);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    // let the read monitor finish the last answer edge before counting
    @(negedge clk_i);
    if (expq.size() != 0) num_errors++;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // the request stays up until waitrequest is seen low; only then is it dropped
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d,
    input logic [31:0] e);
    int n;
    if (!w) expq.push_back(e);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n == 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && expq.size() > 0) begin
      check(avs_readdata_o, expq.pop_front());
    end
  end
  task automatic c0();
    bus(1'b1, 14'h3d30, {en, 2'b0, output_invert, 3'b0, sw}, 32'h0);
  endtask
  task automatic cfg();
    bus(1'b1, 14'h3d38, {3'b0, s}, 32'h0);
    bus(1'b1, 14'h3d3c, {4'h0, l}, 32'h0);
    bus(1'b1, 14'h3d40, {4'h0, h}, 32'h0);
    bus(1'b1, 14'h3d34, {2'b0, hi, hs, 2'b0, li, ls}, 32'h0);
    c0();
  endtask
  task automatic pin();
    // the pin is combinational in clk_i when the clock carrier is chosen: let it settle
    @(negedge clk_i);
    #1;
    check({31'h0, modulated_output_pin_o}, {31'h0, model()});
    @(posedge clk_i);
  endtask
  initial begin
    logic [13:0] ad[7];
    logic [7:0] rb[7];
    int k;
    ad = '{14'h3d30, 14'h3d34, 14'h3d38, 14'h3d3c, 14'h3d40, 14'h3d44, 14'h3d48};
    rb = '{8'h00, 8'h33, 8'h1f, 8'h0f, 8'h0f, 8'h00, 8'h00};
    void'($urandom(32'h9a7c4fb6));
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (k = 0; k < 7; k++) begin
      bus(1'b0, ad[k], 8'h00, 32'h0);
    end
    for (k = 1; k < 7; k++) begin
      if (k != 5) bus(1'b1, ad[k], 8'hff, 32'h0);
      bus(1'b0, ad[k], 8'h00, {24'h0, rb[k]});
    end
    avs_byteenable_i <= 4'h0;
    bus(1'b1, 14'h3d34, 8'h00, 32'h0);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, 14'h3d34, 8'h00, 32'h33);
    bus(1'b1, 14'h3d44, 8'h01, 32'h0);
    bus(1'b0, 14'h3d34, 8'h00, 32'h0);
    bus(1'b0, 14'h3d44, 8'h00, 32'h1);
    bus(1'b1, 14'h3d44, 8'h00, 32'h0);
    bus(1'b0, 14'h3d38, 8'h00, 32'h0);
    for (k = 0; k < 64; k++) begin
      {en, output_invert, sw, hi, li} = 5'($urandom);
      s = k[4:0];
      h = k[3:0];
      l = ~k[3:0];
      pat <= 25'($urandom);
      cfg();
      pin();
      // clock carrier skipped here: the status sample would race the clock edge
      if (h != 4'h1 && l != 4'h1)
        bus(1'b0, 14'h3d30, 8'h00, {en, 1'b0, model(), output_invert, 3'b0, sw});
    end
    en = 1'b0;
    output_invert = 1'b1;
    c0();
    pin();
    en = 1'b1;
    c0();
    pin();
    {s, h, l, output_invert, sw, hi, li, hs, ls} = {5'h01, 8'h00, 6'b010010};
    pat <= 25'h6;
    cfg();
    pin();
    sw = 1'b0;
    c0();
    @(negedge clk_i);
    check({31'h0, modulated_output_pin_o}, 32'h0);
    @(posedge clk_i);
    pat <= 25'h4;
    repeat (2) @(posedge clk_i);
    pin();
    {hs, ls} = 2'b01;
    cfg();
    pin();
    sw = 1'b1;
    c0();
    @(negedge clk_i);
    check({31'h0, modulated_output_pin_o}, 32'h0);
    @(posedge clk_i);
    pat <= 25'h2;
    repeat (2) @(posedge clk_i);
    pin();
    pat <= 25'h6;
    sw = 1'b0;
    c0();
    pin();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 14'h3d34, 8'h00, 32'h0);
    tally_and_finish();
  end
endmodule // cdm_mixer_test
